/* rtl/rlps_top.sv */
// Ring line generator and serial power save control with a Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module rlps_top #(
   parameter int TICK_DIV  = rlps_pkg::TICK_DIV, // Cycles per slow tick
   parameter bit DTR_PS_OK = 1'b1                // Configuration 3 supported
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        RTS_B,
   input  wire logic        DTR_B,
   input  wire logic [7:0]  RXC_DATA,
   input  wire logic        RXC_VALID,
   input  wire logic        TXC_READY,
   input  wire logic        TXC_BUSY,
   output logic      [7:0]  TXC_DATA,
   output logic             TXC_VALID,
   output logic             UART_EN,
   output logic             RI_B
);
   // Reset release through two flip-flops
   logic rst_s1;   // First stage
   logic rst_n;    // Released copy used everywhere

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Slow time base
   rlps_tick_if tk ();

   rlps_prescaler #(.DIV(TICK_DIV)) u_pre (
      .clk   (CLK),
      .rst_n (rst_n),
      .tk    (tk)
   );

   // Bus slave state
   logic        ack;         // Registered acknowledge
   logic        next_ack;
   logic [31:0] dat;         // Registered read data
   logic [31:0] next_dat;
   logic [31:0] rd_mux;      // Read word for the addressed register
   logic        req;         // Request present
   logic        wr;          // Write takes effect this edge
   logic        rd_done;     // Read completes this edge
   logic [5:0]  ev;          // Event strobes this cycle

   // Configuration and data state
   logic [7:0]  ctrl;        // Control register
   logic [7:0]  next_ctrl;
   logic [7:0]  tx_buf;      // Outgoing character held
   logic [7:0]  next_tx_buf;
   logic        tx_pend;     // Outgoing character waiting
   logic        next_tx_pend;
   logic [7:0]  rx_buf;      // Last received character
   logic [7:0]  next_rx_buf;
   logic        rx_valid;    // Unread character present
   logic        next_rx_valid;
   logic        rx_ovr;      // Unread character lost to a new one
   logic        next_rx_ovr;

   // Call and ring state
   rlps_pkg::rlps_call_t call;
   rlps_pkg::rlps_call_t next_call;
   logic [12:0] ccnt;        // Ticks left in the ring phase
   logic [12:0] next_ccnt;
   logic        first;       // Still in the first ring interval
   logic        next_first;
   logic        auto_hit;    // Auto answer fires
   logic        call_end;    // Call answered or dropped
   logic        evt_trig;    // Event one-shot trigger
   logic        evt_active;  // Event one-shot running
   logic        next_ri_b;

   // Power state
   rlps_pkg::rlps_ps_t ps;
   rlps_pkg::rlps_ps_t next_ps;
   logic [12:0] pcnt;        // Ticks left in the power phase
   logic [12:0] next_pcnt;
   logic [1:0]  eff;         // Configuration in force
   logic [1:0]  next_eff;
   logic [1:0]  mode;        // Configuration for this decision
   logic        line_on;     // Selected control line in ON state
   logic        tx_busy;     // A character is pending or on the wire
   logic        tx_allow;    // New character may start

   assign req      = WB_CYC_I & WB_STB_I;
   assign wr       = req & ack & WB_WE_I;
   assign rd_done  = req & ack & ~WB_WE_I;
   assign ev       = (wr && WB_ADR_I == rlps_pkg::ADR_EVENT && WB_SEL_I[0])
                   ? WB_DAT_I[5:0] : 6'h00;

   // Read word for the addressed register, unmapped reads as zero
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (WB_ADR_I)
         rlps_pkg::ADR_CTRL: begin
            rd_mux[7:0] = ctrl;
         end
         rlps_pkg::ADR_STATUS: begin
            rd_mux[rlps_pkg::ST_RI]         = ~RI_B;
            rd_mux[rlps_pkg::ST_CALL]       = (call != rlps_pkg::CALL_NONE);
            rd_mux[rlps_pkg::ST_ACTIVE]     = (ps == rlps_pkg::PS_ACTIVE);
            rd_mux[rlps_pkg::ST_UART]       = UART_EN;
            rd_mux[rlps_pkg::ST_TXPEND]     = tx_pend;
            rd_mux[rlps_pkg::ST_TXBUSY]     = TXC_BUSY;
            rd_mux[rlps_pkg::ST_RTS]        = ~RTS_B;
            rd_mux[rlps_pkg::ST_DTR]        = ~DTR_B;
            rd_mux[rlps_pkg::ST_MODE +: 2]  = eff;
         end
         rlps_pkg::ADR_TXD: begin
            rd_mux[7:0] = tx_buf;
         end
         rlps_pkg::ADR_RXD: begin
            rd_mux[7:0]                = rx_buf;
            rd_mux[rlps_pkg::RXD_VALID] = rx_valid;
            rd_mux[rlps_pkg::RXD_OVR]   = rx_ovr;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // Acknowledge one cycle after the request, drop it the cycle after
   always_comb begin
      next_ack = req & ~ack;
      next_dat = (req & ~ack) ? rd_mux : dat;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         dat <= 32'h00000000;
      end else begin
         ack <= next_ack;
         dat <= next_dat;
      end
   end

   assign WB_ACK_O = ack;
   assign WB_DAT_O = dat;

   // Control, transmit holding and receive registers
   always_comb begin
      next_ctrl     = ctrl;
      next_tx_buf   = tx_buf;
      next_tx_pend  = tx_pend;
      next_rx_buf   = rx_buf;
      next_rx_valid = rx_valid;
      next_rx_ovr   = rx_ovr;
      // Configuration write, code 3 refused where unsupported
      if (wr && WB_ADR_I == rlps_pkg::ADR_CTRL && WB_SEL_I[0]) begin
         next_ctrl = WB_DAT_I[7:0] & 8'h3F;
         if (WB_DAT_I[1:0] == rlps_pkg::PSC_DTR && !DTR_PS_OK) begin
            next_ctrl[rlps_pkg::CTRL_PS +: 2] = ctrl[rlps_pkg::CTRL_PS +: 2];
         end
      end
      // Serializer took the character
      if (TXC_VALID && TXC_READY) begin
         next_tx_pend = 1'b0;
      end
      // New character only into an empty holding register
      if (wr && WB_ADR_I == rlps_pkg::ADR_TXD && WB_SEL_I[0] && !tx_pend) begin
         next_tx_buf  = WB_DAT_I[7:0];
         next_tx_pend = 1'b1;
      end
      // Reading the receive register clears its flags
      if (rd_done && WB_ADR_I == rlps_pkg::ADR_RXD) begin
         next_rx_valid = 1'b0;
         next_rx_ovr   = 1'b0;
      end
      // Reception only when fully awake; a new character wins over the clear
      if (RXC_VALID && ps == rlps_pkg::PS_ACTIVE) begin
         next_rx_buf   = RXC_DATA;
         next_rx_valid = 1'b1;
         if (rx_valid && !rd_done) begin
            next_rx_ovr = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= rlps_pkg::CTRL_RESET;
         tx_buf   <= 8'h00;
         tx_pend  <= 1'b0;
         rx_buf   <= 8'h00;
         rx_valid <= 1'b0;
         rx_ovr   <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         tx_buf   <= next_tx_buf;
         tx_pend  <= next_tx_pend;
         rx_buf   <= next_rx_buf;
         rx_valid <= next_rx_valid;
         rx_ovr   <= next_rx_ovr;
      end
   end

   // Transmit gate: awake, and request-to-send ON when flow control is on
   assign tx_allow  = (ps == rlps_pkg::PS_ACTIVE)
                    & (~ctrl[rlps_pkg::CTRL_FLOW] | ~RTS_B);
   assign TXC_VALID = tx_pend & tx_allow;
   assign TXC_DATA  = tx_buf;
   assign tx_busy   = tx_pend | TXC_BUSY;

   // Call cadence, ring phases independent of any ring message
   assign auto_hit = ctrl[rlps_pkg::CTRL_AUTO] & first & (call == rlps_pkg::CALL_ON) & tk.tick
                   & (ccnt == rlps_pkg::RI_ON_TICKS - rlps_pkg::AUTO_TICKS + 13'h0001);
   assign call_end = ev[rlps_pkg::EV_ANSWER] | ev[rlps_pkg::EV_HANGUP] | auto_hit;

   always_comb begin
      next_call  = call;
      next_ccnt  = ccnt;
      next_first = first;
      unique case (call)
         rlps_pkg::CALL_NONE: begin
            // Call start opens an active phase
            if (ev[rlps_pkg::EV_CALL]) begin
               next_call  = rlps_pkg::CALL_ON;
               next_ccnt  = rlps_pkg::RI_ON_TICKS;
               next_first = 1'b1;
            end
         end
         rlps_pkg::CALL_ON: begin
            // Answer releases the line at once
            if (call_end) begin
               next_call = rlps_pkg::CALL_NONE;
            end else if (tk.tick) begin
               if (ccnt == 13'h0001) begin
                  next_call  = rlps_pkg::CALL_OFF;
                  next_ccnt  = rlps_pkg::RI_OFF_TICKS;
                  next_first = 1'b0;
               end else begin
                  next_ccnt = ccnt - 13'h0001;
               end
            end
         end
         rlps_pkg::CALL_OFF: begin
            // Pause then ring again until answered or dropped
            if (call_end) begin
               next_call = rlps_pkg::CALL_NONE;
            end else if (tk.tick) begin
               if (ccnt == 13'h0001) begin
                  next_call = rlps_pkg::CALL_ON;
                  next_ccnt = rlps_pkg::RI_ON_TICKS;
               end else begin
                  next_ccnt = ccnt - 13'h0001;
               end
            end
         end
         default: begin
            next_call = rlps_pkg::CALL_NONE;
         end
      endcase
   end

   // Message and extended events share one retriggerable interval
   assign evt_trig = (ctrl[rlps_pkg::CTRL_MSG] & ev[rlps_pkg::EV_MSG])
                   | (ctrl[rlps_pkg::CTRL_EXT]
                      & (ev[rlps_pkg::EV_URC] | ev[rlps_pkg::EV_DATA]));

   rlps_retrig #(.LEN(rlps_pkg::RI_ON_TICKS)) u_evt (
      .clk    (CLK),
      .rst_n  (rst_n),
      .tk     (tk),
      .trig   (evt_trig),
      .active (evt_active)
   );

   // Ring line is active low
   assign next_ri_b = ~((call == rlps_pkg::CALL_ON) | evt_active);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         call  <= rlps_pkg::CALL_NONE;
         ccnt  <= 13'h0000;
         first <= 1'b0;
         RI_B  <= 1'b1;
      end else begin
         call  <= next_call;
         ccnt  <= next_ccnt;
         first <= next_first;
         RI_B  <= next_ri_b;
      end
   end

   // While awake, a new configuration is only picked up with no character in flight
   assign mode    = (ps == rlps_pkg::PS_ACTIVE && tx_busy)
                  ? eff : ctrl[rlps_pkg::CTRL_PS +: 2];
   assign line_on = (mode == rlps_pkg::PSC_DTR) ? ~DTR_B : ~RTS_B;

   // Power state machine
   always_comb begin
      next_ps   = ps;
      next_pcnt = pcnt;
      next_eff  = mode;
      unique case (ps)
         rlps_pkg::PS_ACTIVE: begin
            if (mode == rlps_pkg::PSC_CYCLE) begin
               // Active slot runs out, idle once nothing is in flight
               if (tk.tick && pcnt > 13'h0001) begin
                  next_pcnt = pcnt - 13'h0001;
               end
               if (pcnt <= 13'h0001 && !tx_busy) begin
                  next_ps   = rlps_pkg::PS_IDLE;
                  next_pcnt = rlps_pkg::CYC_I_TICKS;
               end
            end else if (mode != rlps_pkg::PSC_OFF) begin
               // Line OFF lets the block sleep
               if (!line_on && !tx_busy) begin
                  next_ps = rlps_pkg::PS_IDLE;
               end
            end
         end
         rlps_pkg::PS_IDLE: begin
            if (mode == rlps_pkg::PSC_OFF) begin
               next_ps = rlps_pkg::PS_ACTIVE;
            end else if (mode == rlps_pkg::PSC_CYCLE) begin
               // Idle slot, then a fresh active slot
               if (tk.tick) begin
                  if (pcnt <= 13'h0001) begin
                     next_ps   = rlps_pkg::PS_ACTIVE;
                     next_pcnt = rlps_pkg::CYC_A_TICKS;
                  end else begin
                     next_pcnt = pcnt - 13'h0001;
                  end
               end
            end else if (line_on) begin
               // Line went ON: start the wake-up time
               next_ps   = rlps_pkg::PS_WAKING;
               next_pcnt = rlps_pkg::WAKE_TICKS;
            end
         end
         rlps_pkg::PS_WAKING: begin
            if (mode == rlps_pkg::PSC_OFF || mode == rlps_pkg::PSC_CYCLE) begin
               next_ps   = rlps_pkg::PS_ACTIVE;
               next_pcnt = rlps_pkg::CYC_A_TICKS;
            end else if (!line_on) begin
               next_ps = rlps_pkg::PS_IDLE;
            end else if (tk.tick) begin
               if (pcnt <= 13'h0001) begin
                  next_ps = rlps_pkg::PS_ACTIVE;
               end else begin
                  next_pcnt = pcnt - 13'h0001;
               end
            end
         end
         default: begin
            next_ps = rlps_pkg::PS_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ps   <= rlps_pkg::PS_ACTIVE;
         pcnt <= 13'h0000;
         eff  <= rlps_pkg::PSC_OFF;
      end else begin
         ps   <= next_ps;
         pcnt <= next_pcnt;
         eff  <= next_eff;
      end
   end

   // Serial interface enabled except while idle
   assign UART_EN = (ps != rlps_pkg::PS_IDLE);
endmodule : rlps_top
`default_nettype wire

/* rtl/rlps_pkg.sv */
// Constants, register map and state types shared by the ring line and power save block
package rlps_pkg;
   // Clock rate and prescaler tick
   localparam int CLK_MHZ  = 125;               // System clock in MHz
   localparam int TICK_US  = 1000;              // Prescaler tick period in us
   localparam int TICK_DIV = TICK_US * CLK_MHZ; // Clock cycles per tick

   // Times in milliseconds
   localparam int RI_ON_MS      = 1000; // Ring line active interval
   localparam int RI_OFF_MS     = 4000; // Ring line pause during a call
   localparam int WAKE_MS       = 20;   // Wake-up time before lossless reception
   localparam int CYC_ACTIVE_MS = 100;  // Cyclic mode active slot
   localparam int CYC_IDLE_MS   = 900;  // Cyclic mode idle slot
   localparam int AUTO_ANS_MS   = 500;  // Delay of the auto answer

   // Tick counts, least times rounded up
   localparam int CNT_W = 13; // Width of all tick counters
   localparam logic [12:0] RI_ON_TICKS  = 13'((RI_ON_MS * 1000 + TICK_US - 1) / TICK_US);
   localparam logic [12:0] RI_OFF_TICKS = 13'((RI_OFF_MS * 1000 + TICK_US - 1) / TICK_US);
   localparam logic [12:0] WAKE_TICKS   = 13'((WAKE_MS * 1000 + TICK_US - 1) / TICK_US);
   localparam logic [12:0] CYC_A_TICKS  = 13'((CYC_ACTIVE_MS * 1000 + TICK_US - 1) / TICK_US);
   localparam logic [12:0] CYC_I_TICKS  = 13'((CYC_IDLE_MS * 1000 + TICK_US - 1) / TICK_US);
   localparam logic [12:0] AUTO_TICKS   = 13'((AUTO_ANS_MS * 1000 + TICK_US - 1) / TICK_US);

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00; // Configuration
   localparam logic [7:0] ADR_EVENT  = 8'h04; // Event strobes, write only
   localparam logic [7:0] ADR_STATUS = 8'h08; // Block state, read only
   localparam logic [7:0] ADR_TXD    = 8'h0C; // Outgoing character
   localparam logic [7:0] ADR_RXD    = 8'h10; // Incoming character

   // Control fields
   localparam int CTRL_PS   = 0; // Two bits: power_save_config
   localparam int CTRL_FLOW = 2; // flow_control_on_setting when set
   localparam int CTRL_MSG  = 3; // message_notify_config enable
   localparam int CTRL_EXT  = 4; // extended_ring_config enable
   localparam int CTRL_AUTO = 5; // auto_answer_setting enable
   localparam logic [7:0] CTRL_RESET = 8'h04; // Flow control on, power saving off

   // Event strobe bits
   localparam int EV_CALL   = 0; // Incoming call starts
   localparam int EV_HANGUP = 1; // Call dropped by the far end
   localparam int EV_MSG    = 2; // Short message arrived
   localparam int EV_URC    = 3; // unsolicited_result issued
   localparam int EV_DATA   = 4; // Incoming data arrived
   localparam int EV_ANSWER = 5; // answer_call_command accepted

   // Status bits
   localparam int ST_RI     = 0;
   localparam int ST_CALL   = 1;
   localparam int ST_ACTIVE = 2;
   localparam int ST_UART   = 3;
   localparam int ST_TXPEND = 4;
   localparam int ST_TXBUSY = 5;
   localparam int ST_RTS    = 6;
   localparam int ST_DTR    = 7;
   localparam int ST_MODE   = 8; // Two bits: configuration in force

   // Receive register bits
   localparam int RXD_VALID = 8;
   localparam int RXD_OVR   = 9;

   // Power save configuration codes
   localparam logic [1:0] PSC_OFF   = 2'h0;
   localparam logic [1:0] PSC_CYCLE = 2'h1;
   localparam logic [1:0] PSC_RTS   = 2'h2;
   localparam logic [1:0] PSC_DTR   = 2'h3;

   // Power state
   typedef enum logic [1:0] {
      PS_ACTIVE = 2'b00,
      PS_IDLE   = 2'b01,
      PS_WAKING = 2'b10
   } rlps_ps_t;

   // Ring cadence of an incoming call
   typedef enum logic [1:0] {
      CALL_NONE = 2'b00,
      CALL_ON   = 2'b01,
      CALL_OFF  = 2'b10
   } rlps_call_t;
endpackage : rlps_pkg

/* rtl/rlps_tick_if.sv */
// Slow time base tick carried from the prescaler to its users
`timescale 1ns/100ps
`default_nettype none
interface rlps_tick_if;
   logic tick; // One-cycle pulse per prescaler period
   modport src (output tick);
   modport snk (input tick);
endinterface : rlps_tick_if
`default_nettype wire

/* rtl/rlps_prescaler.sv */
// Free-running prescaler that makes the slow tick
`timescale 1ns/100ps
`default_nettype none
module rlps_prescaler #(
   parameter int DIV = rlps_pkg::TICK_DIV
) (
   input wire logic clk,
   input wire logic rst_n,
   rlps_tick_if.src tk
);
   localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

   // Refuse ratios the counter cannot serve
   if (DIV < 2) begin : g_chk
      $error("Prescaler ratio must be at least 2");
   end

   logic [W-1:0] cnt;      // Cycles left in this period
   logic [W-1:0] next_cnt;
   logic         next_tick;
   logic         tick_q;   // Registered tick

   // Count down and reload, tick on wrap
   always_comb begin
      next_tick = (cnt == '0);
      next_cnt  = next_tick ? W'(DIV - 1) : cnt - 1'b1;
   end

   // Registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt    <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         tick_q <= next_tick;
      end
   end

   assign tk.tick = tick_q;
endmodule : rlps_prescaler
`default_nettype wire

/* rtl/rlps_retrig.sv */
// Retriggerable one-shot counted in slow ticks
`timescale 1ns/100ps
`default_nettype none
module rlps_retrig #(
   parameter logic [12:0] LEN = rlps_pkg::RI_ON_TICKS
) (
   input  wire logic clk,
   input  wire logic rst_n,
   rlps_tick_if.snk  tk,
   input  wire logic trig,
   output logic      active
);
   // Refuse a zero length
   if (LEN == 13'h0000) begin : g_chk
      $error("One-shot length must be nonzero");
   end

   logic [12:0] cnt;      // Ticks left of the active interval
   logic [12:0] next_cnt;

   // Each trigger reloads the full interval, the line never drops between
   always_comb begin
      next_cnt = cnt;
      if (trig) begin
         next_cnt = LEN;
      end else if (tk.tick && cnt != 13'h0000) begin
         next_cnt = cnt - 13'h0001;
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 13'h0000;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign active = (cnt != 13'h0000);
endmodule : rlps_retrig
`default_nettype wire

/* testbench/rlps_host.sv */
// Host terminal model: control lines and the serial character path
`timescale 1ns/100ps
`default_nettype none
module rlps_host (
   input  wire logic       clk,
   input  wire logic       rts_on,
   input  wire logic       dtr_on,
   input  wire logic [7:0] txc_data,
   input  wire logic       txc_valid,
   output logic            rts_b,
   output logic            dtr_b,
   output logic            txc_ready,
   output logic            txc_busy,
   output logic [7:0]      rxc_data = 8'h00,
   output logic            rxc_valid = 1'b0,
   output logic [7:0]      last_tx = 8'h00
);
   int busy_n = 0; // Cycles left of the character on the wire
   // Host lines are ON when low
   assign rts_b = !rts_on;
   assign dtr_b = !dtr_on;
   assign txc_busy = busy_n != 0;
   assign txc_ready = busy_n == 0;
   // Take a character, then stay busy while it goes out
   always @(posedge clk) begin
      if (txc_valid && txc_ready) begin
         busy_n <= 10;
         last_tx <= txc_data;
      end else if (busy_n != 0) begin
         busy_n <= busy_n - 1;
      end
   end
   // One character toward the block; the line then shows the inverse
   task automatic send(input logic [7:0] c);
      @(posedge clk);
      {rxc_valid, rxc_data} <= {1'b1, c};
      @(posedge clk);
      {rxc_valid, rxc_data} <= {1'b0, ~c};
   endtask : send
endmodule : rlps_host
`default_nettype wire

/* testbench/rlps_top_sva.sv */
// Port checker for the ring line and power save block
`timescale 1ns/100ps
`default_nettype none
module rlps_top_chk (
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        TXC_READY,
   input wire logic [7:0]  TXC_DATA,
   input wire logic        TXC_VALID,
   input wire logic        UART_EN,
   input wire logic        RI_B
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   a_ack_has_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack unasked");
   a_unmapped_zero: assert property (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O
      && WB_ADR_I == 8'h14 |=> WB_DAT_O == 32'h0) else $error("unmapped data");
   a_start_off: assert property ($rose(RST_B) |-> RI_B && UART_EN)
      else $error("start state");
   a_ring_min_on: assert property ($fell(RI_B) |-> !RI_B [*8])
      else $error("ring short");
   a_tx_only_awake: assert property (TXC_VALID |-> UART_EN)
      else $error("tx asleep");
   a_tx_data_held: assert property (TXC_VALID && !TXC_READY |=> $stable(TXC_DATA))
      else $error("tx data moved");
   a_tx_one_char: assert property (TXC_VALID && TXC_READY |=> !TXC_VALID)
      else $error("tx repeated");
endmodule : rlps_top_chk
bind rlps_top rlps_top_chk u_chk (.CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
   .WB_DAT_O, .WB_ACK_O, .TXC_READY, .TXC_DATA, .TXC_VALID, .UART_EN, .RI_B);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the ring line and power save block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        CLK = 1'b0, RST_B = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0]  WB_ADR_I = 8'h00, RXC_DATA, TXC_DATA, last_tx;
   logic [31:0] WB_DAT_I = 32'h00000000, WB_DAT_O, q;
   logic        WB_ACK_O, RTS_B, DTR_B, RXC_VALID, TXC_READY, TXC_BUSY;
   logic        TXC_VALID, UART_EN, RI_B, rts_on = 1, dtr_on = 1;
   int          miscompares = 0, checks = 0, n;
   initial forever #4 CLK = ~CLK;
   rlps_top #(.TICK_DIV(4)) uut (.CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
      .WB_SEL_I(4'h1), .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .RTS_B, .DTR_B, .RXC_DATA,
      .RXC_VALID, .TXC_READY, .TXC_BUSY, .TXC_DATA, .TXC_VALID, .UART_EN, .RI_B);
   rlps_host host (.clk(CLK), .rts_on, .dtr_on, .txc_data(TXC_DATA), .txc_valid(TXC_VALID),
      .rts_b(RTS_B), .dtr_b(DTR_B), .txc_ready(TXC_READY), .txc_busy(TXC_BUSY),
      .rxc_data(RXC_DATA), .rxc_valid(RXC_VALID), .last_tx);
   task automatic give_verdict;
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask : chk
   // One classic cycle; read data lands in q at the ack edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge CLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
      for (k = 0; k < 20 && WB_ACK_O !== 1'b1; k++) @(posedge CLK);
      if (k == 20) begin
         chk("ack", 1, 0);
         give_verdict();
      end
      q = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'b00;
   endtask : wb
   // Count cycles until the ring line (w 0) or serial enable (w 1) shows v
   task automatic wt(input int w, input logic v, input int lim);
      for (n = 0; n < lim && (w == 0 ? RI_B : UART_EN) !== v; n++) @(posedge CLK);
      if (n == lim) begin
         chk("wait", 1, 0);
         give_verdict();
      end
   endtask : wt
   task automatic t_ring;
      wb(1, 8'h00, 32'h1C);
      wb(1, 8'h04, 32'h04);
      wt(0, 0, 8);
      repeat (2000) @(posedge CLK);
      wb(1, 8'h04, 32'h08);
      wt(0, 1, 5000);
      chk("retrig", 1, 32'(n inside {[3985:4010]}));
      wb(1, 8'h00, 32'h04);
      wb(1, 8'h04, 32'h01);
      wt(0, 0, 8);
      wt(0, 1, 5000);
      chk("ring_on", 1, 32'(n inside {[3990:4010]}));
      wt(0, 0, 17000);
      chk("ring_off", 1, 32'(n inside {[15990:16010]}));
      repeat (100) @(posedge CLK);
      wb(1, 8'h04, 32'h20);
      wt(0, 1, 4);
      // Auto answer ends the first ring after half an interval
      wb(1, 8'h00, 32'h24);
      wb(1, 8'h04, 32'h01);
      wt(0, 0, 8);
      wt(0, 1, 2100);
      chk("auto_answer", 1, 32'(n inside {[1990:2010]}));
   endtask : t_ring
   task automatic t_xfer;
      rts_on <= 1'b0;
      wb(1, 8'h0C, 32'h5A);
      repeat (20) @(posedge CLK);
      chk("gated", 0, 32'(TXC_VALID));
      rts_on <= 1'b1;
      repeat (20) @(posedge CLK);
      chk("tx", 8'h5A, last_tx);
      wb(1, 8'h00, 32'h00);
      rts_on <= 1'b0;
      wb(1, 8'h0C, 32'hA5);
      repeat (20) @(posedge CLK);
      chk("ungated", 8'hA5, last_tx);
      rts_on <= 1'b1;
      host.send(8'h3C);
      wb(0, 8'h10, 0);
      chk("rxd", 32'h13C, q);
   endtask : t_xfer
   task automatic t_power;
      for (int m = 2; m < 4; m++) begin
         wb(1, 8'h00, 32'(m));
         {rts_on, dtr_on} <= 2'b00;
         wt(1, 0, 50);
         {rts_on, dtr_on} <= (m == 2) ? 2'b10 : 2'b01;
         wt(1, 1, 5);
         repeat (100) @(posedge CLK);
         wb(0, 8'h08, 0);
         chk("awake", 1, 32'(q[2]));
      end
      wb(1, 8'h00, 32'h05);
      wt(1, 0, 500);
      host.send(8'h11);
      wb(0, 8'h10, 0);
      chk("rx_idle", 0, 32'(q[8]));
      wt(1, 1, 3700);
      host.send(8'h22);
      wb(0, 8'h10, 0);
      chk("rx_active", 32'h122, q);
   endtask : t_power
   initial begin
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (4) @(posedge CLK);
      chk("ri", 1, 32'(RI_B));
      wb(0, 8'h00, 0);
      chk("ctrl", 32'h04, q);
      wb(0, 8'h14, 0);
      chk("unmapped", 0, q);
      t_ring();
      t_xfer();
      t_power();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
